// file: core/thermal_pkg.sv
// Shared constants and carrier types for the thermal throttle controller
package thermal_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 50;
   // One modulation slot of the clock gating pattern, in ns
   localparam int MOD_SLOT_NS = 1000;
   // Longest time rounds down, never below one cycle
   localparam int MOD_SLOT_CYC = (MOD_SLOT_NS / CLK_PERIOD_NS) < 1 ? 1 :
      (MOD_SLOT_NS / CLK_PERIOD_NS);
   localparam int DIV_W = 8;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_SLOT_CYC - 1);

   // Operating point code width, larger code means faster and hotter
   localparam int OP_W = 4;
   // Duty width: on-slots out of eight per modulation period
   localparam int DUTY_W = 3;
   localparam logic [DUTY_W-1:0] DUTY_AUTO = 3'h4;
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 3'h0;

   // Register byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_OD_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_OP_REQ = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_OP_TGT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h18;

   // Field positions
   localparam int F_OD_DUTY_LO = 1;
   localparam int F_OD_EN = 4;
   localparam int F_AUTO_EN = 0;
   localparam int F_VARIANT = 1;
   localparam int F_ST_TCC = 0;
   localparam int F_ST_HOT = 1;
   localparam int F_ST_CLK = 2;
   localparam int F_ST_DEFER = 3;
   localparam int F_ST_OP_LO = 8;

   // Interrupt events
   localparam int IRQ_N = 3;
   localparam int EV_TCC_ON = 0;
   localparam int EV_TCC_OFF = 1;
   localparam int EV_DEFER = 2;

   // Automatic variant select
   typedef enum logic {
      VAR_CLOCK_MOD,
      VAR_OP_POINT
   } variant_e;

   // Avalon-MM request from the master
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avs_req_s;

   // Avalon-MM answer to the master
   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } avs_rsp_s;
endpackage

// file: core/thermal_throttle_control.sv
// Thermal throttle controller with Avalon-MM register slave
module thermal_throttle_control
   import thermal_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic trip_in,
   input wire logic ext_irq,
   input wire logic snoop_req,
   input wire avs_req_s avs_req,
   output avs_rsp_s avs_rsp,
   output logic core_clk_en,
   output logic [OP_W-1:0] op_point,
   output logic op_change,
   output logic tcc_active,
   output logic irq_service,
   output logic snoop_ack,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic trip_s1; // First sync stage, read only by second
      logic trip_s2;
      logic xirq_s1;
      logic xirq_s2;
      logic snp_s1;
      logic snp_s2;
      logic od_en; // On-demand enable
      logic [DUTY_W-1:0] od_duty; // On-demand on-slots
      logic auto_en; // Automatic mode enable
      variant_e variant; // Automatic variant
      logic [OP_W-1:0] sw_req; // Last software request
      logic [OP_W-1:0] tgt; // Thermal target point
      logic [OP_W-1:0] op; // Applied operating point
      logic op_chg;
      logic thermal_control_circuit;
      logic clk_en;
      logic [DIV_W-1:0] div; // Slot prescaler
      logic [DUTY_W-1:0] phase; // Slot within period
      logic irq_pend; // Latched external interrupt
      logic irq_srv;
      logic snp_ack;
      logic [IRQ_N-1:0] ist; // Sticky event status
      logic [IRQ_N-1:0] imask;
      logic irq;
      logic wait_n; // Low for the one answer cycle
      logic [31:0] rdata;
   } state_s;

   state_s s_q; // Registered state
   state_s s_d; // Next state

   // Combinational helpers
   logic auto_hot; // Automatic mode sees trip
   logic gate_on; // Clock gating in effect
   logic op_thr; // Operating point throttling in effect
   logic [DUTY_W-1:0] duty; // Chosen on-slot count
   logic [OP_W-1:0] op_goal; // Where the operating point should be
   logic acc; // Bus access completes this edge
   logic wr_acc;
   logic [IRQ_N-1:0] ev; // Events this cycle
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      s_d = s_q;
      // Sync stages: first stage feeds only the second
      s_d.trip_s1 = trip_in;
      s_d.trip_s2 = s_q.trip_s1;
      s_d.xirq_s1 = ext_irq;
      s_d.xirq_s2 = s_q.xirq_s1;
      s_d.snp_s1 = snoop_req;
      s_d.snp_s2 = s_q.snp_s1;

      // fixed trip
      // Threshold lives in the analog comparator, nothing here to program
      // trip gated activation
      auto_hot = s_q.auto_en && s_q.trip_s2;
      gate_on = (auto_hot && s_q.variant == VAR_CLOCK_MOD) ||
         (!auto_hot && s_q.od_en);
      op_thr = auto_hot && s_q.variant == VAR_OP_POINT;
      if (auto_hot) begin
         duty = DUTY_AUTO;
      end else if (s_q.od_duty == DUTY_ZERO) begin
         // Zero code would starve the core, treat as half duty
         duty = DUTY_AUTO;
      end else begin
         duty = s_q.od_duty;
      end

      s_d.thermal_control_circuit = auto_hot || s_q.od_en;

      if (s_q.div == DIV_LAST) begin
         s_d.div = '0;
         s_d.phase = s_q.phase + 1'b1;
      end else begin
         s_d.div = s_q.div + 1'b1;
      end
      if (!gate_on) begin
         // Restart pattern so each throttle episode begins clocked
         s_d.div = '0;
         s_d.phase = '0;
      end
      s_d.clk_en = !gate_on || (s_d.phase < duty);

      if (op_thr && s_q.tgt < s_q.sw_req) begin
         op_goal = s_q.tgt;
      end else begin
         op_goal = s_q.sw_req;
      end
      s_d.op = op_goal;
      s_d.op_chg = op_goal != s_q.op;

      // interrupts wait for running clocks
      // A request level held over several cycles is served again;
      // the latch keeps no count, only that something is pending
      s_d.irq_srv = 1'b0;
      if (s_q.xirq_s2) begin
         s_d.irq_pend = 1'b1;
      end
      if (s_q.irq_pend && s_q.clk_en && !s_q.irq_srv) begin
         s_d.irq_srv = 1'b1;
         s_d.irq_pend = s_q.xirq_s2;
      end
      s_d.snp_ack = s_q.snp_s2;

      // Avalon: answer one cycle after the request appears.
      // Waitrequest idles high and drops for exactly one cycle; the
      // master holds its request until it sees it low, so the access
      // completes on that edge and no earlier. Acting on the first
      // edge would land writes while waitrequest still says wait.
      acc = (avs_req.read || avs_req.write) && !s_q.wait_n;
      wr_acc = acc && avs_req.write;
      // Drop for one cycle, then back high even if the request stays
      s_d.wait_n = !((avs_req.read || avs_req.write) && s_q.wait_n);
      rd_mux = '0;
      case (avs_req.address)
         OFF_OD_CTRL: begin
            rd_mux[F_OD_EN] = s_q.od_en;
            rd_mux[F_OD_DUTY_LO +: DUTY_W] = s_q.od_duty;
         end
         OFF_MODE: begin
            rd_mux[F_AUTO_EN] = s_q.auto_en;
            rd_mux[F_VARIANT] = s_q.variant;
         end
         OFF_OP_REQ: rd_mux[OP_W-1:0] = s_q.sw_req;
         OFF_OP_TGT: rd_mux[OP_W-1:0] = s_q.tgt;
         OFF_STATUS: begin
            rd_mux[F_ST_TCC] = s_q.thermal_control_circuit;
            rd_mux[F_ST_HOT] = s_q.trip_s2;
            rd_mux[F_ST_CLK] = s_q.clk_en;
            rd_mux[F_ST_DEFER] = op_thr && (s_q.sw_req > s_q.tgt);
            rd_mux[F_ST_OP_LO +: OP_W] = s_q.op;
         end
         OFF_IRQ_STAT: rd_mux[IRQ_N-1:0] = s_q.ist;
         OFF_IRQ_MASK: rd_mux[IRQ_N-1:0] = s_q.imask;
         // Unmapped reads give zero
         default: rd_mux = '0;
      endcase
      // Read data is captured as waitrequest drops, so it stands in
      // the answer cycle and is zero at every other time
      s_d.rdata = (avs_req.read && s_q.wait_n) ? rd_mux : '0;

      // Events; status bit set wins over a same-cycle clear
      ev = '0;
      ev[EV_TCC_ON] = s_d.thermal_control_circuit && !s_q.thermal_control_circuit;
      ev[EV_TCC_OFF] = !s_d.thermal_control_circuit && s_q.thermal_control_circuit;
      ev[EV_DEFER] = 1'b0;

      if (wr_acc) begin
         case (avs_req.address)
            OFF_OD_CTRL: begin
               s_d.od_en = avs_req.writedata[F_OD_EN];
               s_d.od_duty = avs_req.writedata[F_OD_DUTY_LO +: DUTY_W];
            end
            OFF_MODE: begin
               s_d.auto_en = avs_req.writedata[F_AUTO_EN];
               s_d.variant = variant_e'(avs_req.writedata[F_VARIANT]);
            end
            OFF_OP_REQ: begin
               s_d.sw_req = avs_req.writedata[OP_W-1:0];
               ev[EV_DEFER] = op_thr &&
                  (avs_req.writedata[OP_W-1:0] > s_q.tgt);
            end
            OFF_OP_TGT: s_d.tgt = avs_req.writedata[OP_W-1:0];
            OFF_IRQ_STAT: begin
               s_d.ist = s_q.ist & ~avs_req.writedata[IRQ_N-1:0];
            end
            OFF_IRQ_MASK: s_d.imask = avs_req.writedata[IRQ_N-1:0];
            // Unmapped and read-only writes are dropped
            default: ;
         endcase
      end
      s_d.ist = s_d.ist | ev;
      s_d.irq = |(s_d.ist & s_d.imask);
   end

   ////////////////////////////////////////////////////////////////////
   // State register; leaves automatic mode to firmware
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.clk_en <= 1'b1;
         s_q.wait_n <= 1'b1;
         s_q.variant <= VAR_CLOCK_MOD;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops
   assign avs_rsp.waitrequest = s_q.wait_n;
   assign avs_rsp.readdata = s_q.rdata;
   assign core_clk_en = s_q.clk_en;
   assign op_point = s_q.op;
   assign op_change = s_q.op_chg;
   assign tcc_active = s_q.thermal_control_circuit;
   assign irq_service = s_q.irq_srv;
   assign snoop_ack = s_q.snp_ack;
   assign irq = s_q.irq;

   ////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   a_auto_trip_active: assert property (
      s_q.auto_en && s_q.trip_s2 |=> s_q.thermal_control_circuit)
      else $error("automatic trip did not activate throttling");
   a_idle_inactive: assert property (
      !s_q.od_en && !(s_q.auto_en && s_q.trip_s2) |=> !s_q.thermal_control_circuit)
      else $error("throttling active without cause");
   a_ondemand_active: assert property (
      s_q.od_en |=> s_q.thermal_control_circuit)
      else $error("on-demand bit did not activate throttling");
   a_op_no_gating: assert property (
      s_q.auto_en && s_q.trip_s2 && s_q.variant == VAR_OP_POINT
      ##1 s_q.auto_en && s_q.trip_s2 |-> s_q.clk_en)
      else $error("clock gated while operating point variant rules");
   a_op_target: assert property (
      s_q.auto_en && s_q.trip_s2 && s_q.variant == VAR_OP_POINT
      && s_q.tgt < s_q.sw_req |=> s_q.op == $past(s_q.tgt))
      else $error("operating point not lowered to target");
   a_op_restore: assert property (
      !(s_q.auto_en && s_q.trip_s2) |=> s_q.op == $past(s_q.sw_req))
      else $error("operating point not restored");
   a_lower_now: assert property (
      s_q.auto_en && s_q.trip_s2 && s_q.variant == VAR_OP_POINT
      && s_q.sw_req <= s_q.tgt |=> s_q.op == $past(s_q.sw_req))
      else $error("lower request not applied at once");
   a_half_duty: assert property (
      s_q.auto_en && s_q.trip_s2 && s_q.variant == VAR_CLOCK_MOD
      && s_q.phase >= DUTY_AUTO && s_q.div != DIV_LAST |=> !s_q.clk_en)
      else $error("clock running in off half of modulation");
   a_serve_clocked: assert property (
      s_q.irq_srv |-> $past(s_q.clk_en) && $past(s_q.irq_pend))
      else $error("interrupt served while clocks off");
   a_irq_level: assert property (
      s_q.irq == |(s_q.ist & s_q.imask))
      else $error("interrupt output disagrees with status");
   a_bus_answer: assert property (
      (avs_req.read || avs_req.write) && s_q.wait_n |=> !s_q.wait_n)
      else $error("bus request not answered in one cycle");

   c_auto_clock_mod: cover property (
      s_q.thermal_control_circuit && s_q.variant == VAR_CLOCK_MOD ##1 !s_q.clk_en);
   c_op_throttle: cover property (s_q.op_chg && s_q.thermal_control_circuit);
   c_defer_event: cover property (s_q.ist[EV_DEFER]);
   c_irq_served: cover property (s_q.irq_srv && s_q.thermal_control_circuit);
endmodule

// file: verification/trip_clock_model.sv
// Behavioural trip comparator and interrupt source beside the core
module trip_clock_model (
   input wire logic sys_clk,
   input wire logic hot,
   input wire logic irq_pulse,
   output logic trip_in,
   output logic ext_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   // Comparator output is low until the first edge
   initial trip_in = 1'b0;
   initial ext_irq = 1'b0;
   // threshold fixed here, only hot or not
   // one level, changed right after an edge
   always @(posedge sys_clk) begin
      trip_in <= hot;
      ext_irq <= irq_pulse;
   end
endmodule

// file: verification/thermal_throttle_control_tb.sv
// Self-checking bench for the thermal throttle controller
module thermal_throttle_control_tb;
   import thermal_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rst, hot, irq_pulse, snoop_req, trip_in, ext_irq;
   logic core_clk_en, op_change, tcc_active, irq_service, snoop_ack, irq;
   logic [OP_W-1:0] op_point, hi_op, lo_op;
   avs_req_s avs_req;
   avs_rsp_s avs_rsp;
   int err_count, n_tests, cyc, seed, k, on_n, n_chg;
   logic [31:0] rd;
   logic clk_seen; // Clock state at the edge that served an interrupt
   // Device under test
   thermal_throttle_control uut (.sys_clk(sys_clk), .rst(rst),
      .trip_in(trip_in), .ext_irq(ext_irq), .snoop_req(snoop_req),
      .avs_req(avs_req), .avs_rsp(avs_rsp), .core_clk_en(core_clk_en),
      .op_point(op_point), .op_change(op_change), .tcc_active(tcc_active),
      .irq_service(irq_service), .snoop_ack(snoop_ack), .irq(irq));
   // Far side: comparator and interrupt source
   trip_clock_model partner (.sys_clk(sys_clk), .hot(hot),
      .irq_pulse(irq_pulse), .trip_in(trip_in), .ext_irq(ext_irq));
   ////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One Avalon access; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      avs_req <= '{a, !wr, wr, d};
      do @(posedge sys_clk); while (avs_rsp.waitrequest);
      rd = avs_rsp.readdata;
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Wait n edges, counting operating point change pulses on the way
   task automatic cyc_n(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         n_chg += op_change;
      end
   endtask
   // On cycles expected in one eight-slot period
   function automatic int exp_on(input int duty);
      return duty * MOD_SLOT_CYC;
   endfunction
   // Any whole period of a running pattern holds the same count
   task automatic count_on();
      on_n = 0;
      repeat (8 * MOD_SLOT_CYC) begin
         @(negedge sys_clk);
         on_n += core_clk_en;
      end
      @(posedge sys_clk);
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Hang guard, well above the few thousand cycles needed
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_count++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      hot = 1'b0;
      irq_pulse = 1'b0;
      snoop_req = 1'b0;
      avs_req = '0;
      seed = 32'hB180;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      bus(0, OFF_STATUS, 0);
      chk(rd, 32'h4);
      bus(0, 8'h1C, 0);
      chk(rd, 0);
      $display("End of test: reset view");
      bus(1, OFF_IRQ_MASK, 32'h7);
      bus(1, OFF_MODE, 32'h1);
      cyc_n(10);
      chk(tcc_active, 0);
      bus(1, OFF_OD_CTRL, 32'h12);
      hot <= 1'b1;
      cyc_n(10);
      chk(irq, 1);
      bus(0, OFF_STATUS, 0);
      chk(rd[1:0], 2'h3);
      count_on();
      chk(on_n, exp_on(4));
      bus(1, OFF_IRQ_STAT, 32'h7);
      chk(irq, 0);
      irq_pulse <= 1'b1;
      snoop_req <= 1'b1;
      cyc_n(2);
      irq_pulse <= 1'b0;
      cyc_n(3);
      chk(snoop_ack, 1);
      k = 0;
      clk_seen = 1'b0;
      // Keep the clock state that the serving edge acted on
      while (irq_service !== 1'b1 && k < 200) begin
         clk_seen = core_clk_en;
         @(posedge sys_clk);
         k++;
      end
      chk(irq_service, 1);
      chk(clk_seen, 1);
      hot <= 1'b0;
      snoop_req <= 1'b0;
      bus(1, OFF_OD_CTRL, 0);
      cyc_n(10);
      chk(tcc_active, 0);
      count_on();
      chk(on_n, exp_on(8));
      $display("End of test: automatic clock modulation");
      for (int d = 1; d < 8; d++) begin
         bus(1, OFF_OD_CTRL, 32'h10 | (d << 1));
         cyc_n(3);
         chk(tcc_active, 1);
         cyc_n(170);
         count_on();
         chk(on_n, exp_on(d));
      end
      bus(1, OFF_OD_CTRL, 0);
      $display("End of test: on-demand duty");
      hi_op = 4'h8 | 4'($random(seed) & 7);
      lo_op = 4'h1 + 4'($random(seed) & 3);
      bus(1, OFF_MODE, 32'h3);
      bus(1, OFF_OP_TGT, 32'h6);
      bus(1, OFF_OP_REQ, 32'(hi_op));
      cyc_n(5);
      chk(op_point, hi_op);
      n_chg = 0;
      hot <= 1'b1;
      cyc_n(10);
      chk(op_point, 4'h6);
      chk(n_chg, 1);
      chk(core_clk_en, 1);
      bus(1, OFF_OP_REQ, 32'(hi_op ^ 4'h1));
      cyc_n(5);
      chk(op_point, 4'h6);
      bus(0, OFF_IRQ_STAT, 0);
      chk(rd[2], 1);
      hot <= 1'b0;
      cyc_n(10);
      chk(op_point, hi_op ^ 4'h1);
      hot <= 1'b1;
      cyc_n(10);
      bus(1, OFF_OP_REQ, 32'(lo_op));
      cyc_n(5);
      chk(op_point, lo_op);
      hot <= 1'b0;
      cyc_n(10);
      chk(op_point, lo_op);
      $display("End of test: operating point");
      conclude();
   end
endmodule
